// ===== hdl/speed_command_selector.sv
// Purpose: picks the running frequency command from contacts, jog and analog inputs
// Assumes: terminal inputs synchronous to clk; settings held stable by the host
// Notes:   multi-speed result lags the debounced inputs by two cycles
`timescale 1ns/10ps
module speed_command_selector #(
  parameter int NUM_TERMINALS = 7
) (
  input  wire logic                                       clk,
  input  wire logic                                       reset_n,
  input  wire logic [NUM_TERMINALS-1:0]                   terminalIn,
  input  wire logic [NUM_TERMINALS*speed_sel_pkg::FUNC_W-1:0] terminalFunction,
  input  wire logic                                       forwardStart,
  input  wire logic                                       reverseStart,
  input  wire logic                                       panelRunKey,
  input  wire logic                                       panelJogMode,
  input  wire logic                                       externalMode,
  input  wire logic [speed_sel_pkg::MODE_W-1:0]           operationModeSetting,
  input  wire logic [speed_sel_pkg::REMOTE_W-1:0]         remoteFunctionSetting,
  input  wire logic                                       rampTimeIncrement,
  input  wire logic                                       speedWrite,
  input  wire logic [speed_sel_pkg::IDX_W-1:0]            speedWriteIndex,
  input  wire logic                                       jogFreqWrite,
  input  wire logic                                       rampTimeWrite,
  input  wire logic                                       rampRefWrite,
  input  wire logic [speed_sel_pkg::RAMP_W-1:0]           settingData,
  input  wire logic                                       analogSecondValid,
  input  wire logic [speed_sel_pkg::FREQ_W-1:0]           analogSecondFreq,
  input  wire logic [speed_sel_pkg::FREQ_W-1:0]           analogFirstFreq,
  output logic      [speed_sel_pkg::FREQ_W-1:0]           freqCommand_r,
  output logic      [speed_sel_pkg::SRC_W-1:0]            freqSource_r,
  output logic                                            runForward_r,
  output logic                                            runReverse_r,
  output logic                                            jogRunning_r,
  output logic      [speed_sel_pkg::RAMP_OUT_W-1:0]       jogRampTime_r,
  output logic      [speed_sel_pkg::FREQ_W-1:0]           rampRefFreq_r,
  output logic                                            settingAccepted_r,
  output logic                                            settingRejected_r
);
  // Terminals, two starts and the run key
  localparam int NUM_IN = NUM_TERMINALS + 3;
  localparam int DB_CNT_W = $clog2(speed_sel_pkg::DEBOUNCE_CYCLES + 1);
  localparam logic [DB_CNT_W-1:0] DB_LAST = DB_CNT_W'(speed_sel_pkg::DEBOUNCE_CYCLES - 1);
  localparam logic [DB_CNT_W-1:0] DB_ZERO = '0;

  logic [NUM_IN-1:0]   rawIn;
  logic [NUM_IN-1:0]   stable_r;
  logic [DB_CNT_W-1:0] dbCnt_r [NUM_IN];

  assign rawIn = {panelRunKey, reverseStart, forwardStart, terminalIn};

  // Debounce: a level is taken only after it held for the full count
  for (genvar i = 0; i < NUM_IN; i++) begin : gDebounce
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        dbCnt_r[i]  <= DB_ZERO;
        stable_r[i] <= 1'b0;
      end else if (rawIn[i] == stable_r[i]) begin
        dbCnt_r[i] <= DB_ZERO;
      end else if (dbCnt_r[i] == DB_LAST) begin
        dbCnt_r[i]  <= DB_ZERO;
        stable_r[i] <= rawIn[i];
      end else begin
        dbCnt_r[i] <= dbCnt_r[i] + 1'b1;
      end
    end
  end

  // Per-terminal function hits
  logic [NUM_TERMINALS-1:0] termStable;
  logic [NUM_TERMINALS-1:0] isLow;
  logic [NUM_TERMINALS-1:0] isMid;
  logic [NUM_TERMINALS-1:0] isHigh;
  logic [NUM_TERMINALS-1:0] isExt;
  logic [NUM_TERMINALS-1:0] isJog;

  assign termStable = stable_r[NUM_TERMINALS-1:0];

  // Function code decode per terminal; several terminals may share one function
  for (genvar t = 0; t < NUM_TERMINALS; t++) begin : gFunc
    wire logic [speed_sel_pkg::FUNC_W-1:0] code =
      terminalFunction[t*speed_sel_pkg::FUNC_W +: speed_sel_pkg::FUNC_W];
    assign isLow[t]  = termStable[t] && (code == speed_sel_pkg::FUNC_LOW_SPEED);
    assign isMid[t]  = termStable[t] && (code == speed_sel_pkg::FUNC_MID_SPEED);
    assign isHigh[t] = termStable[t] && (code == speed_sel_pkg::FUNC_HIGH_SPEED);
    assign isExt[t]  = termStable[t] && (code == speed_sel_pkg::FUNC_SPEED_EXT);
    assign isJog[t]  = termStable[t] && (code == speed_sel_pkg::FUNC_JOG_SELECT);
  end

  // Debounced select, start and run key lines
  wire logic lowSel   = |isLow;
  wire logic midSel   = |isMid;
  wire logic highSel  = |isHigh;
  wire logic extSel   = |isExt;
  wire logic jogSel   = |isJog;
  wire logic fwdIn    = stable_r[NUM_TERMINALS];
  wire logic revIn    = stable_r[NUM_TERMINALS+1];
  wire logic runKeyIn = stable_r[NUM_TERMINALS+2];

  // Fixed map from the four select lines {ext, high, middle, low} to a slot
  function automatic logic [speed_sel_pkg::IDX_W-1:0] speedSlot(input logic [3:0] sel);
    logic [speed_sel_pkg::IDX_W-1:0] slot;
    slot = speed_sel_pkg::IDX_NONE;
    case (sel)
      4'h0:    slot = speed_sel_pkg::IDX_NONE;
      4'h1:    slot = speed_sel_pkg::IDX_LOW;
      4'h2:    slot = speed_sel_pkg::IDX_MID;
      4'h4:    slot = speed_sel_pkg::IDX_HIGH;
      4'h3:    slot = 4'h4;
      4'h5:    slot = 4'h5;
      4'h6:    slot = 4'h6;
      default: slot = sel; // Triple selection and ext combinations map straight onto speeds 7 to 15
    endcase
    return slot;
  endfunction

  logic [speed_sel_pkg::IDX_W-1:0] tableSlot;
  logic [speed_sel_pkg::IDX_W-1:0] basicSlot;

  // Combination slot and the basic slot it falls back to
  assign tableSlot = speedSlot({extSel, highSel, midSel, lowSel});
  // Lowest-ranked active input wins; extension alone falls back to low speed
  assign basicSlot = lowSel  ? speed_sel_pkg::IDX_LOW :
                     midSel  ? speed_sel_pkg::IDX_MID :
                     highSel ? speed_sel_pkg::IDX_HIGH :
                     extSel  ? speed_sel_pkg::IDX_LOW :
                               speed_sel_pkg::IDX_NONE;

  // Multi-speed gate
  wire logic modeAllowsMulti = (operationModeSetting == speed_sel_pkg::MODE_EXTERNAL) ||
                               (operationModeSetting == speed_sel_pkg::MODE_COMBINED);
  wire logic remoteOff = (remoteFunctionSetting == speed_sel_pkg::REMOTE_OFF);
  wire logic multiReq = modeAllowsMulti && remoteOff &&
                        (tableSlot != speed_sel_pkg::IDX_NONE);

  // Speed setting writes: range check, unset marker only for extended slots
  wire logic [speed_sel_pkg::FREQ_W-1:0] freqData = settingData;
  wire logic freqInRange = (freqData <= speed_sel_pkg::FREQ_MAX);
  wire logic extSlot     = (speedWriteIndex >= speed_sel_pkg::IDX_FIRST_EXT);
  wire logic speedOk = (speedWriteIndex != speed_sel_pkg::IDX_NONE) &&
                       (freqInRange || (extSlot && (freqData == speed_sel_pkg::NOT_SELECTED)));
  // No operation mode term here: speed settings stay writable in every mode
  wire logic speedWriteGo = speedWrite && speedOk;
  // Jog and ramp settings: range checks only
  wire logic jogFreqOk  = freqInRange;
  wire logic rampTimeOk = (settingData <= speed_sel_pkg::RAMP_TIME_MAX);
  wire logic rampRefOk  = freqInRange;
  wire logic anyWrite = speedWrite || jogFreqWrite || rampTimeWrite || rampRefWrite;
  wire logic writeOk  = (speedWrite && speedOk) || (jogFreqWrite && jogFreqOk) ||
                        (rampTimeWrite && rampTimeOk) || (rampRefWrite && rampRefOk);

  // Memory read data, one cycle behind the index
  logic [speed_sel_pkg::FREQ_W-1:0] slotFreq;
  logic [speed_sel_pkg::FREQ_W-1:0] basicFreq;

  speed_setting_mem #(
    .DEPTH(16)
  ) uSpeedMem (
    .clk        (clk),
    .reset_n    (reset_n),
    .writeEn    (speedWriteGo),
    .writeIndex (speedWriteIndex),
    .writeData  (freqData),
    .readIndexA (tableSlot),
    .readIndexB (basicSlot),
    .readDataA  (slotFreq),
    .readDataB  (basicFreq)
  );

  // Align the request with the memory's registered read data
  logic multiReq_r;
  logic extSlotSel_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      multiReq_r   <= 1'b0;
      extSlotSel_r <= 1'b0;
    end else begin
      multiReq_r   <= multiReq;
      extSlotSel_r <= (tableSlot >= speed_sel_pkg::IDX_FIRST_EXT);
    end
  end

  // Unset extended speed drops back to the basic selection
  wire logic slotUnset = extSlotSel_r && (slotFreq == speed_sel_pkg::NOT_SELECTED);
  wire logic [speed_sel_pkg::FREQ_W-1:0] multiFreq = slotUnset ? basicFreq : slotFreq;

  // Jog settings registers
  logic [speed_sel_pkg::FREQ_W-1:0] jogFreq_r;
  logic [speed_sel_pkg::RAMP_W-1:0] rampRaw_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      jogFreq_r     <= speed_sel_pkg::JOG_FREQ_RST;
      rampRaw_r     <= speed_sel_pkg::RAMP_TIME_RST;
      rampRefFreq_r <= speed_sel_pkg::RAMP_REF_RST;
    end else begin
      if (jogFreqWrite && jogFreqOk) begin
        jogFreq_r <= freqData;
      end

      if (rampTimeWrite && rampTimeOk) begin
        rampRaw_r <= settingData;
      end

      if (rampRefWrite && rampRefOk) begin
        rampRefFreq_r <= freqData;
      end
    end
  end

  // Ramp time in 10 ms units; raw count is read in the current increment
  wire logic [speed_sel_pkg::RAMP_OUT_W-1:0] rampWide = {4'h0, rampRaw_r};
  wire logic [speed_sel_pkg::RAMP_OUT_W-1:0] rampTime10ms =
    rampTimeIncrement ? rampWide
                      : speed_sel_pkg::RAMP_OUT_W'(rampWide * speed_sel_pkg::RAMP_COARSE_SCALE);

  // Run state: jog only if jog select was already on when start arrived
  speed_sel_pkg::run_state_type state_r;
  speed_sel_pkg::run_state_type state_nxt;
  wire logic startAny = fwdIn || revIn;
  wire logic extJogOk = externalMode && jogSel;
  wire logic panelJogOk = !externalMode && panelJogMode;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      speed_sel_pkg::RUN_IDLE: begin
        if (extJogOk && fwdIn) begin
          state_nxt = speed_sel_pkg::RUN_JOG_FWD;
        end else if (extJogOk && revIn) begin
          state_nxt = speed_sel_pkg::RUN_JOG_REV;
        end else if (startAny) begin
          state_nxt = speed_sel_pkg::RUN_NORMAL;
        end else if (panelJogOk && runKeyIn) begin
          state_nxt = speed_sel_pkg::RUN_PANEL_JOG;
        end
      end

      speed_sel_pkg::RUN_JOG_FWD: begin
        if (!fwdIn || !jogSel) begin
          state_nxt = speed_sel_pkg::RUN_IDLE;
        end
      end

      speed_sel_pkg::RUN_JOG_REV: begin
        if (!revIn || !jogSel) begin
          state_nxt = speed_sel_pkg::RUN_IDLE;
        end
      end

      speed_sel_pkg::RUN_NORMAL: begin
        // Start before jog select stays an ordinary run until released
        if (!startAny) begin
          state_nxt = speed_sel_pkg::RUN_IDLE;
        end
      end

      speed_sel_pkg::RUN_PANEL_JOG: begin
        if (!runKeyIn || !panelJogOk) begin
          state_nxt = speed_sel_pkg::RUN_IDLE;
        end
      end

      default: state_nxt = speed_sel_pkg::RUN_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= speed_sel_pkg::RUN_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Direction and jog decode of the next state
  wire logic jogNxt = (state_nxt == speed_sel_pkg::RUN_JOG_FWD) ||
                      (state_nxt == speed_sel_pkg::RUN_JOG_REV) ||
                      (state_nxt == speed_sel_pkg::RUN_PANEL_JOG);
  // Both starts in a normal run cancel each other, as a safe stop
  wire logic fwdNxt = (state_nxt == speed_sel_pkg::RUN_JOG_FWD) ||
                      (state_nxt == speed_sel_pkg::RUN_PANEL_JOG) ||
                      ((state_nxt == speed_sel_pkg::RUN_NORMAL) && fwdIn && !revIn);
  wire logic revNxt = (state_nxt == speed_sel_pkg::RUN_JOG_REV) ||
                      ((state_nxt == speed_sel_pkg::RUN_NORMAL) && revIn && !fwdIn);

  // Command priority: jog, then multi-speed, then second and first analog
  logic [speed_sel_pkg::FREQ_W-1:0] cmdNxt;
  logic [speed_sel_pkg::SRC_W-1:0]  srcNxt;
  assign cmdNxt = jogNxt            ? jogFreq_r :
                  multiReq_r        ? multiFreq :
                  analogSecondValid ? analogSecondFreq :
                                      analogFirstFreq;

  // Source code in the same order
  assign srcNxt = jogNxt            ? speed_sel_pkg::SRC_JOG :
                  multiReq_r        ? speed_sel_pkg::SRC_MULTI :
                  analogSecondValid ? speed_sel_pkg::SRC_ANALOG2 :
                                      speed_sel_pkg::SRC_ANALOG1;

  // Output registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freqCommand_r     <= speed_sel_pkg::ZERO_FREQ;
      freqSource_r      <= speed_sel_pkg::SRC_ANALOG1;
      runForward_r      <= 1'b0;
      runReverse_r      <= 1'b0;
      jogRunning_r      <= 1'b0;
      jogRampTime_r     <= '0;
      settingAccepted_r <= 1'b0;
      settingRejected_r <= 1'b0;
    end else begin
      freqCommand_r     <= cmdNxt;
      freqSource_r      <= srcNxt;
      runForward_r      <= fwdNxt;
      runReverse_r      <= revNxt;
      jogRunning_r      <= jogNxt;
      jogRampTime_r     <= rampTime10ms;
      settingAccepted_r <= anyWrite && writeOk;
      settingRejected_r <= anyWrite && !writeOk;
    end
  end
endmodule

// ===== hdl/speed_sel_pkg.sv
// Purpose: shared constants of the speed command selector
// Assumes: frequencies in 0.1 Hz steps, ramp times in raw setting steps
// Notes:   the not-selected marker lies above the 400 Hz ceiling, so it is unambiguous
package speed_sel_pkg;
  // Widths
  localparam int FREQ_W    = 16;
  localparam int FUNC_W    = 8;
  localparam int IDX_W     = 4;
  localparam int RAMP_W    = 16;
  localparam int RAMP_OUT_W = 20;
  localparam int MODE_W    = 3;
  localparam int REMOTE_W  = 2;
  localparam int SRC_W     = 3;

  // Input terminal function codes
  localparam logic [FUNC_W-1:0] FUNC_LOW_SPEED  = 8'h00;
  localparam logic [FUNC_W-1:0] FUNC_MID_SPEED  = 8'h01;
  localparam logic [FUNC_W-1:0] FUNC_HIGH_SPEED = 8'h02;
  localparam logic [FUNC_W-1:0] FUNC_JOG_SELECT = 8'h05;
  localparam logic [FUNC_W-1:0] FUNC_SPEED_EXT  = 8'h08;

  // Frequency limits and reset values, 0.1 Hz steps
  localparam logic [FREQ_W-1:0] FREQ_MAX       = 16'h0FA0; // 400 Hz
  localparam logic [FREQ_W-1:0] NOT_SELECTED   = 16'h270F; // 9999
  localparam logic [FREQ_W-1:0] HIGH_FREQ_RST  = 16'h01F4; // 50 Hz
  localparam logic [FREQ_W-1:0] MID_FREQ_RST   = 16'h012C; // 30 Hz
  localparam logic [FREQ_W-1:0] LOW_FREQ_RST   = 16'h0064; // 10 Hz
  localparam logic [FREQ_W-1:0] JOG_FREQ_RST   = 16'h0032; // 5 Hz
  localparam logic [FREQ_W-1:0] RAMP_REF_RST   = 16'h01F4; // 50 Hz
  localparam logic [FREQ_W-1:0] ZERO_FREQ      = 16'h0000;

  // Speed memory slots
  localparam logic [IDX_W-1:0] IDX_NONE   = 4'h0;
  localparam logic [IDX_W-1:0] IDX_HIGH   = 4'h1;
  localparam logic [IDX_W-1:0] IDX_MID    = 4'h2;
  localparam logic [IDX_W-1:0] IDX_LOW    = 4'h3;
  localparam logic [IDX_W-1:0] IDX_FIRST_EXT = 4'h4;

  // Jog ramp time: 0.5 s in 0.1 s steps, same count bound for both increments
  localparam logic [RAMP_W-1:0] RAMP_TIME_RST = 16'h0005;
  localparam logic [RAMP_W-1:0] RAMP_TIME_MAX = 16'h8CA0; // 3600 s or 360 s
  localparam logic [RAMP_OUT_W-1:0] RAMP_COARSE_SCALE = 20'h0000A; // 0.1 s in 10 ms

  // Operation mode values that allow multi-speed
  localparam logic [MODE_W-1:0] MODE_EXTERNAL = 3'h3;
  localparam logic [MODE_W-1:0] MODE_COMBINED = 3'h4;
  localparam logic [REMOTE_W-1:0] REMOTE_OFF  = 2'h0;

  // Frequency command source codes
  localparam logic [SRC_W-1:0] SRC_ANALOG1 = 3'h0;
  localparam logic [SRC_W-1:0] SRC_ANALOG2 = 3'h1;
  localparam logic [SRC_W-1:0] SRC_MULTI   = 3'h2;
  localparam logic [SRC_W-1:0] SRC_JOG     = 3'h3;

  // Input debounce
  localparam int CLK_PERIOD_NS    = 8;
  localparam int DEBOUNCE_TIME_NS = 80;
  localparam int DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RUN_IDLE,
    RUN_JOG_FWD,
    RUN_JOG_REV,
    RUN_NORMAL,
    RUN_PANEL_JOG
  } run_state_type;
endpackage

// ===== hdl/speed_setting_mem.sv
// Purpose: speed frequency settings, one write port, two registered reads
// Assumes: slot 1..3 high/middle/low, slots 4..15 extended speeds
// Notes:   slot 0 is never written and reads zero
`timescale 1ns/10ps
module speed_setting_mem #(
  parameter int DEPTH = 16
) (
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              writeEn,
  input  wire logic [speed_sel_pkg::IDX_W-1:0]   writeIndex,
  input  wire logic [speed_sel_pkg::FREQ_W-1:0]  writeData,
  input  wire logic [speed_sel_pkg::IDX_W-1:0]   readIndexA,
  input  wire logic [speed_sel_pkg::IDX_W-1:0]   readIndexB,
  output logic      [speed_sel_pkg::FREQ_W-1:0]  readDataA,
  output logic      [speed_sel_pkg::FREQ_W-1:0]  readDataB
);
  logic [speed_sel_pkg::FREQ_W-1:0] slot_r [DEPTH];

  // One flop per slot; extended speeds come up not selected
  for (genvar i = 0; i < DEPTH; i++) begin : gSlot
    localparam logic [speed_sel_pkg::FREQ_W-1:0] RST_VAL =
      (i == 0) ? speed_sel_pkg::ZERO_FREQ :
      (i == 1) ? speed_sel_pkg::HIGH_FREQ_RST :
      (i == 2) ? speed_sel_pkg::MID_FREQ_RST :
      (i == 3) ? speed_sel_pkg::LOW_FREQ_RST : speed_sel_pkg::NOT_SELECTED;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        slot_r[i] <= RST_VAL;
      end else if (writeEn && (writeIndex == speed_sel_pkg::IDX_W'(i)) && (i != 0)) begin
        slot_r[i] <= writeData;
      end
    end
  end

  // Registered read ports
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readDataA <= speed_sel_pkg::ZERO_FREQ;
      readDataB <= speed_sel_pkg::ZERO_FREQ;
    end else begin
      readDataA <= slot_r[readIndexA];
      readDataB <= slot_r[readIndexB];
    end
  end
endmodule

// ===== test/speed_command_selector_properties.sv
// Purpose: port-level checks of the speed command selector
// Assumes: one clock domain, reset_n asynchronous and active low
// Notes:   stop bounds are debounce 10 edges plus one state edge and one spare edge
`timescale 1ns/10ps
module speed_command_selector_properties (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        forwardStart,
  input wire logic        reverseStart,
  input wire logic        panelRunKey,
  input wire logic [2:0]  operationModeSetting,
  input wire logic [1:0]  remoteFunctionSetting,
  input wire logic        speedWrite,
  input wire logic        jogFreqWrite,
  input wire logic        rampTimeWrite,
  input wire logic        rampRefWrite,
  input wire logic [15:0] settingData,
  input wire logic [2:0]  freqSource_r,
  input wire logic        runForward_r,
  input wire logic        runReverse_r,
  input wire logic        jogRunning_r,
  input wire logic        settingAccepted_r,
  input wire logic        settingRejected_r
);
  logic [3:0] quiet_r;
  logic [2:0] badMode_r;
  logic       anyWrite;
  logic       modeOk;
  // Decoded causes
  assign anyWrite = speedWrite | jogFreqWrite | rampTimeWrite | rampRefWrite;
  assign modeOk = (operationModeSetting inside {3'h3, 3'h4}) && (remoteFunctionSetting == 2'h0);
  // Saturating run lengths, so a long quiet spell never wraps to zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_r <= 4'h0;
      badMode_r <= 3'h0;
    end else begin
      quiet_r <= (forwardStart | reverseStart | panelRunKey) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
      badMode_r <= modeOk ? 3'h0 : badMode_r + {2'h0, badMode_r != 3'h7};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  write_answer_a: assert property (anyWrite |=> settingAccepted_r || settingRejected_r)
    else $error("write strobe got no answer pulse");
  idle_quiet_a: assert property (!anyWrite |=> !settingAccepted_r && !settingRejected_r)
    else $error("answer pulse without a write");
  jog_range_a: assert property (jogFreqWrite && settingData > speed_sel_pkg::FREQ_MAX |=> settingRejected_r)
    else $error("jog frequency above ceiling not refused");
  ramp_range_a: assert property (rampTimeWrite && settingData > speed_sel_pkg::RAMP_TIME_MAX |=> settingRejected_r)
    else $error("ramp time above ceiling not refused");
  jog_source_a: assert property (jogRunning_r |-> freqSource_r == speed_sel_pkg::SRC_JOG)
    else $error("jog running without jog source");
  dir_excl_a: assert property (!(runForward_r && runReverse_r))
    else $error("both run directions at once");
  jog_stop_a: assert property (quiet_r >= 4'hC |-> !jogRunning_r)
    else $error("jog still running after starts released");
  multi_gate_a: assert property (badMode_r == 3'h7 |-> freqSource_r != speed_sel_pkg::SRC_MULTI)
    else $error("multi-speed used in a barred mode");
  jog_seen_c: cover property ($rose(jogRunning_r));
  refuse_seen_c: cover property (settingRejected_r);
  multi_seen_c: cover property (freqSource_r == speed_sel_pkg::SRC_MULTI);
endmodule
bind speed_command_selector speed_command_selector_properties chk_u (.*);

// ===== test/contact_model.sv
// Purpose: switch contacts on the terminals and start inputs
// Assumes: terminals 0..3 low, middle, high, extension; terminal 4 jog select
// Notes:   terminals 5 and 6 are left open and read low
`timescale 1ns/10ps
module contact_model (
  input wire logic  clk,
  input wire logic [3:0] speedReq,
  input wire logic  jogReq,
  input wire logic  fwdReq,
  input wire logic  revReq,
  output logic [6:0] terminalIn = 7'h00,
  output logic      forwardStart = 1'b0,
  output logic      reverseStart = 1'b0
);
  logic [3:0] jogAge_r = 4'h0;
  logic       startOk;
  // A start waits until jog select has cleared the debounce
  assign startOk = !jogReq || (jogAge_r >= 4'hC);
  // Contacts change just after the edge
  always @(posedge clk) begin
    jogAge_r <= !jogReq ? 4'h0 : jogAge_r + {3'h0, jogAge_r != 4'hF};
    terminalIn <= {2'h0, jogReq, speedReq};
    forwardStart <= fwdReq && startOk;
    reverseStart <= revReq && startOk;
  end
endmodule

// ===== test/tb.sv
// Purpose: scenario bench of the speed command selector
// Assumes: design defaults after reset, no settings written beforehand
// Notes:   fixed settle time covers model, debounce and output pipeline
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0, reset_n = 1'b0, forwardStart, reverseStart, jogReq = 1'b0;
  logic panelRunKey = 1'b0, panelJogMode = 1'b0, externalMode = 1'b0, rampTimeIncrement = 1'b0;
  logic speedWrite = 1'b0, jogFreqWrite = 1'b0, rampTimeWrite = 1'b0, rampRefWrite = 1'b0;
  logic analogSecondValid = 1'b0, fwdReq = 1'b0, revReq = 1'b0;
  logic [6:0]  terminalIn;
  logic [55:0] terminalFunction = 56'h10100508020100;
  logic [2:0]  operationModeSetting = 3'h3, freqSource_r;
  logic [1:0]  remoteFunctionSetting = 2'h0;
  logic [3:0]  speedWriteIndex = 4'h0, speedReq = 4'h0;
  logic [15:0] settingData = 16'h0000, analogSecondFreq = 16'h0222, analogFirstFreq = 16'h0111;
  logic [15:0] freqCommand_r, rampRefFreq_r;
  logic [19:0] jogRampTime_r;
  logic        runForward_r, runReverse_r, jogRunning_r, settingAccepted_r, settingRejected_r;
  int          mismatches = 0, n_checks = 0;
  always #4 clk = ~clk;
  contact_model partner_u (.clk(clk), .speedReq(speedReq), .jogReq(jogReq), .fwdReq(fwdReq),
    .revReq(revReq), .terminalIn(terminalIn), .forwardStart(forwardStart),
    .reverseStart(reverseStart));
  speed_command_selector dut_u (.*);
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic settle;
    repeat (30) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [3:0] s, input logic j, input logic f, input logic r);
    @(posedge clk);
    speedReq <= s;
    jogReq <= j;
    fwdReq <= f;
    revReq <= r;
    settle;
  endtask
  // One strobe, answer judged on the following edge
  task automatic wr(input int kind, input logic [3:0] idx, input logic [15:0] d, input logic ok);
    @(posedge clk);
    speedWrite <= (kind == 0);
    jogFreqWrite <= (kind == 1);
    rampTimeWrite <= (kind == 2);
    rampRefWrite <= (kind == 3);
    speedWriteIndex <= idx;
    settingData <= d;
    @(posedge clk);
    {speedWrite, jogFreqWrite, rampTimeWrite, rampRefWrite} <= 4'h0;
    #1;
    chk("write answer", {18'h0, ok, !ok}, {18'h0, settingAccepted_r, settingRejected_r});
  endtask
  task automatic mode(input logic [2:0] m, input logic [1:0] r, input logic a2);
    @(posedge clk);
    operationModeSetting <= m;
    remoteFunctionSetting <= r;
    analogSecondValid <= a2;
    settle;
  endtask
  task automatic t_reset;
    settle;
    chk("ramp ref", 20'h001F4, {4'h0, rampRefFreq_r});
    chk("jog ramp", 20'h00032, jogRampTime_r);
    chk("freq", 20'h00111, {4'h0, freqCommand_r});
  endtask
  // Single, paired, triple and extension-only selections
  task automatic t_basic;
    logic [3:0]  code [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8};
    logic [15:0] fq [6] = '{16'h0064, 16'h012C, 16'h01F4, 16'h012C, 16'h0064, 16'h0064};
    for (int i = 0; i < 6; i++) begin
      cmd(code[i], 1'b0, 1'b0, 1'b0);
      chk("multi freq", {4'h0, fq[i]}, {4'h0, freqCommand_r});
      chk("multi src", 20'h2, {17'h0, freqSource_r});
    end
  endtask
  task automatic t_ext;
    wr(0, 4'h8, 16'h04D2, 1'b1);
    wr(0, 4'hD, 16'h0309, 1'b1);
    wr(0, 4'h0, 16'h0064, 1'b0);
    wr(0, 4'h5, 16'h0FA1, 1'b0);
    cmd(4'h8, 1'b0, 1'b0, 1'b0);
    chk("speed 8", 20'h004D2, {4'h0, freqCommand_r});
    cmd(4'hD, 1'b0, 1'b0, 1'b0);
    chk("speed 13", 20'h00309, {4'h0, freqCommand_r});
    cmd(4'hC, 1'b0, 1'b0, 1'b0);
    chk("speed 12 unset", 20'h001F4, {4'h0, freqCommand_r});
  endtask
  task automatic t_gate;
    cmd(4'h1, 1'b0, 1'b0, 1'b0);
    mode(3'h1, 2'h0, 1'b1);
    chk("mode 1 src", 20'h1, {17'h0, freqSource_r});
    chk("analog 2", 20'h00222, {4'h0, freqCommand_r});
    mode(3'h4, 2'h0, 1'b1);
    chk("mode 4 src", 20'h2, {17'h0, freqSource_r});
    mode(3'h3, 2'h1, 1'b1);
    chk("remote src", 20'h1, {17'h0, freqSource_r});
    mode(3'h3, 2'h0, 1'b0);
  endtask
  task automatic t_jog;
    @(posedge clk);
    externalMode <= 1'b1;
    cmd(4'h1, 1'b1, 1'b1, 1'b0);
    chk("jog fwd", 20'h3, {18'h0, jogRunning_r, runForward_r});
    chk("jog src", 20'h3, {17'h0, freqSource_r});
    chk("jog freq", 20'h00032, {4'h0, freqCommand_r});
    wr(1, 4'h0, 16'h0FA1, 1'b0);
    wr(1, 4'h0, 16'h0FA0, 1'b1);
    settle;
    chk("jog freq max", 20'h00FA0, {4'h0, freqCommand_r});
    cmd(4'h1, 1'b1, 1'b0, 1'b0);
    chk("jog stop", 20'h0, {19'h0, jogRunning_r});
    cmd(4'h1, 1'b1, 1'b0, 1'b1);
    chk("jog rev", 20'h3, {18'h0, jogRunning_r, runReverse_r});
    cmd(4'h1, 1'b0, 1'b1, 1'b0);
    chk("normal run", 20'h1, {18'h0, jogRunning_r, runForward_r});
    cmd(4'h0, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    externalMode <= 1'b0;
  endtask
  task automatic t_panel;
    @(posedge clk);
    panelJogMode <= 1'b1;
    panelRunKey <= 1'b1;
    settle;
    chk("panel jog", 20'h1, {19'h0, jogRunning_r});
    @(posedge clk);
    panelRunKey <= 1'b0;
    settle;
    chk("panel stop", 20'h0, {19'h0, jogRunning_r});
    wr(3, 4'h0, 16'h03E8, 1'b1);
    wr(3, 4'h0, 16'h0FA1, 1'b0);
    chk("ramp ref set", 20'h003E8, {4'h0, rampRefFreq_r});
    @(posedge clk);
    rampTimeIncrement <= 1'b1;
    wr(2, 4'h0, 16'h012C, 1'b1);
    wr(2, 4'h0, 16'h8CA1, 1'b0);
    settle;
    chk("ramp fine", 20'h0012C, jogRampTime_r);
    @(posedge clk);
    rampTimeIncrement <= 1'b0;
    settle;
    chk("ramp coarse", 20'h00BB8, jogRampTime_r);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_basic;
    t_ext;
    t_gate;
    t_jog;
    t_panel;
    close_out;
  end
  // Hang guard
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule
